// >>> verilog/mxs_pkg.sv
// Purpose: Constants and types for the instruction execution subset.
// Assumes: APB register access, pclk at 40 MHz.
// Notes:   Shared by the execution core and its bench.
//
// Summary of operation
// RQ1 - AND accumulator with file, route, zero flag
// RQ2 - Add accumulator and file, carry flags, zero
// RQ3 - Clear selected file bit, flags unchanged
// RQ4 - Set selected file bit, flags unchanged
// RQ5 - AND literal into accumulator, zero flag
// RQ6 - Bit set skips next instruction, two cycles
// RQ7 - Bit clear skips next instruction, two cycles
// RQ8 - Clear file register, set zero flag
// RQ9 - Clear accumulator, set zero flag
// RQ10 - Call pushes PC+1, loads page and target
// RQ11 - Jump loads page and target, no push
// RQ12 - Watchdog clear resets count, sets timeout, power-down
// RQ13 - Increment or decrement, route, zero flag
// RQ14 - Decrement, skip when zero, flags unchanged
// RQ15 - Increment, skip when zero, flags unchanged
// RQ16 - Complement file register, route, zero flag
// RQ17 - Four clocks per cycle; branches add NOP
`default_nettype none
package mxs_pkg;

    // ****************************************************************
    // Timing
    // ****************************************************************
    localparam int          CLK_PERIOD_NS   = 25;
    localparam logic [1:0]  CLKS_PER_CYCLE_M1 = 2'h3;

    // ****************************************************************
    // Register offsets
    // ****************************************************************
    localparam logic [11:0] ADDR_CMD        = 12'h000;
    localparam logic [11:0] ADDR_ACC        = 12'h004;
    localparam logic [11:0] ADDR_STATUS     = 12'h008;
    localparam logic [11:0] ADDR_PC         = 12'h00C;
    localparam logic [11:0] ADDR_PAGE       = 12'h010;
    localparam logic [11:0] ADDR_SP         = 12'h014;
    localparam logic [11:0] ADDR_STACK_TOP  = 12'h018;
    localparam logic [2:0]  FILE_SEL        = 3'h2;

    // ****************************************************************
    // Field positions
    // ****************************************************************
    localparam int CMD_OP_LSB = 0;
    localparam int CMD_F_LSB  = 5;
    localparam int CMD_D_BIT  = 12;
    localparam int CMD_B_LSB  = 13;
    localparam int CMD_K_LSB  = 16;
    localparam int STAT_C     = 0;
    localparam int STAT_DIGIT = 1;
    localparam int STAT_Z     = 2;
    localparam int STAT_PWRDN = 3;
    localparam int STAT_TMOUT = 4;
    localparam int STAT_BUSY  = 8;
    localparam int STAT_SKIP  = 9;

    // ****************************************************************
    // Reset values
    // ****************************************************************
    localparam logic [7:0]  ACC_RST    = 8'h00;
    localparam logic [4:0]  FLAGS_RST  = 5'h18;
    localparam logic [12:0] PC_RST     = 13'h0000;
    localparam logic [4:0]  PAGE_RST   = 5'h00;

    // ****************************************************************
    // Operations and sequencer states
    // ****************************************************************
    // Five code bits so that jump and watchdog clear each have their own code.
    typedef enum logic [4:0] {
        and_acc_with_file, add_acc_to_file, complement_op, increment_op,
        decrement_op, decrement_skip_zero, increment_skip_zero, bit_clear_op,
        bit_set_op, test_skip_if_clear, test_skip_if_set, and_literal_op,
        clear_register_op, clear_accumulator_op, call_op, jump_op, watchdog_clear_op
    } mxs_op_type;

    typedef enum logic [1:0] {SEQ_IDLE, SEQ_READY, SEQ_NOP} mxs_seq_type;

endpackage
`default_nettype wire

// >>> verilog/mxs_exec.sv
// Purpose: Executes one instruction of the subset per instruction cycle.
// Assumes: Software issues instructions through the command register.
// Notes:   File registers, stack and flags are held locally.
`timescale 1ns/1ps
`default_nettype none
module mxs_exec (
    // Clock and reset
    input  wire logic          pclk,
    input  wire logic          presetn,
    // APB slave
    input  wire logic          psel,
    input  wire logic          penable,
    input  wire logic          pwrite,
    input  wire logic [11:0]   paddr,
    input  wire logic [31:0]   pwdata,
    output var  logic [31:0]   prdata,
    output var  logic          pready,
    output var  logic          pslverr,
    // Watchdog
    output var  logic          watchdog_clear
);
    import mxs_pkg::*;

    // ****************************************************************
    // State
    // ****************************************************************
    typedef struct packed {
        logic [1:0]          div;
        logic                tick;
        mxs_seq_type         seq;
        logic                skip;
        logic [4:0]          op;
        logic [6:0]          f;
        logic                d;
        logic [2:0]          b;
        logic [10:0]         k;
        logic [7:0]          acc;
        logic [4:0]          flags;
        logic [12:0]         pc;
        logic [4:0]          page;
        logic [2:0]          sp;
        logic [7:0][12:0]    stack;
        logic [127:0][7:0]   mem;
        logic [31:0]         prdata;
        logic                pready;
        logic                pslverr;
        logic                wdog_clr;
    } mxs_state_type;

    mxs_state_type s_ff;
    mxs_state_type nxt_s;

    logic [7:0]  fv;
    logic [8:0]  add_sum;
    logic [4:0]  nib_sum;
    logic        fire;

    assign fv      = s_ff.mem[s_ff.f];
    assign add_sum = {1'b0, s_ff.acc} + {1'b0, fv};
    assign nib_sum = {1'b0, s_ff.acc[3:0]} + {1'b0, fv[3:0]};
    assign fire    = s_ff.tick && (s_ff.seq == SEQ_READY) && !s_ff.skip;

    // ****************************************************************
    // Decode helpers
    // ****************************************************************
    function automatic logic mapped(input logic [11:0] a);
        mapped = (a[1:0] == 2'b00) && ((a[11:9] == FILE_SEL) || (a <= ADDR_STACK_TOP));
    endfunction

    function automatic logic [31:0] reg_read(input mxs_state_type s, input logic [11:0] a);
        reg_read = 32'h0000_0000;
        if (a[11:9] == FILE_SEL)
        begin
            reg_read = {24'h00_0000, s.mem[a[8:2]]};
        end
        else
        begin
            unique case (a)
                ADDR_CMD:       reg_read = {5'h00, s.k, s.b, s.d, s.f, s.op};
                ADDR_ACC:       reg_read = {24'h00_0000, s.acc};
                ADDR_STATUS:    reg_read = {22'h00_0000, s.skip, s.seq != SEQ_IDLE,
                                            3'h0, s.flags};
                ADDR_PC:        reg_read = {19'h0_0000, s.pc};
                ADDR_PAGE:      reg_read = {27'h000_0000, s.page};
                ADDR_SP:        reg_read = {29'h0000_0000, s.sp};
                ADDR_STACK_TOP: reg_read = {19'h0_0000, s.stack[s.sp - 3'h1]};
                default:        reg_read = 32'h0000_0000;
            endcase
        end
    endfunction

    // ****************************************************************
    // Next state
    // ****************************************************************
    always_comb
    begin
        logic [7:0] res;
        logic       route;
        logic       setup;
        logic       wr;
        res   = 8'h00;
        route = 1'b0;
        nxt_s = s_ff;
        setup = psel && !penable;
        wr    = psel && penable && s_ff.pready && pwrite && !s_ff.pslverr;

        // One instruction cycle is four clocks.
        nxt_s.div     = s_ff.div + 2'h1;
        nxt_s.tick    = (s_ff.div == CLKS_PER_CYCLE_M1); // RQ17
        nxt_s.wdog_clr = 1'b0;

        // Read data is captured in the setup phase so outputs stay registered.
        nxt_s.pready  = setup;
        nxt_s.pslverr = 1'b0;
        if (setup)
        begin
            nxt_s.prdata  = mapped(paddr) ? reg_read(s_ff, paddr) : 32'h0000_0000;
            nxt_s.pslverr = !mapped(paddr)
                            || (pwrite && paddr == ADDR_CMD && s_ff.seq != SEQ_IDLE);
        end

        if (wr)
        begin
            if (paddr[11:9] == FILE_SEL)
            begin
                nxt_s.mem[paddr[8:2]] = pwdata[7:0];
            end
            else
            begin
                unique case (paddr)
                    ADDR_CMD:
                    begin
                        nxt_s.op  = pwdata[CMD_OP_LSB +: 5];
                        nxt_s.f   = pwdata[CMD_F_LSB +: 7];
                        nxt_s.d   = pwdata[CMD_D_BIT];
                        nxt_s.b   = pwdata[CMD_B_LSB +: 3];
                        nxt_s.k   = pwdata[CMD_K_LSB +: 11];
                        nxt_s.seq = SEQ_READY;
                    end
                    ADDR_ACC:    nxt_s.acc   = pwdata[7:0];
                    ADDR_STATUS: nxt_s.flags = pwdata[4:0];
                    ADDR_PC:     nxt_s.pc    = pwdata[12:0];
                    ADDR_PAGE:   nxt_s.page  = pwdata[4:0];
                    default:     nxt_s.prdata = s_ff.prdata;
                endcase
            end
        end

        // Execution is applied after the bus write so hardware updates win.
        if (s_ff.tick)
        begin
            unique case (s_ff.seq)
                // An idle tick leaves the sequencer alone, so a command written now survives.
                SEQ_IDLE:  ;
                SEQ_NOP:   nxt_s.seq = SEQ_IDLE; // RQ17
                SEQ_READY:
                begin
                    nxt_s.seq = SEQ_IDLE;
                    nxt_s.pc  = s_ff.pc + 13'h0001;
                    if (s_ff.skip)
                    begin
                        // The discarded instruction costs one cycle as a NOP.
                        nxt_s.skip = 1'b0; // RQ6 RQ7 RQ14 RQ15
                    end
                    else
                    begin
                        unique case (s_ff.op)
                            and_acc_with_file:
                            begin
                                res   = s_ff.acc & fv; // RQ1
                                route = 1'b1;
                                nxt_s.flags[STAT_Z] = (res == 8'h00);
                            end
                            add_acc_to_file:
                            begin
                                res   = add_sum[7:0]; // RQ2
                                route = 1'b1;
                                nxt_s.flags[STAT_C]  = add_sum[8];
                                nxt_s.flags[STAT_DIGIT] = nib_sum[4];
                                nxt_s.flags[STAT_Z]  = (res == 8'h00);
                            end
                            complement_op:
                            begin
                                res   = ~fv; // RQ16
                                route = 1'b1;
                                nxt_s.flags[STAT_Z] = (res == 8'h00);
                            end
                            increment_op, decrement_op:
                            begin
                                res   = (s_ff.op == increment_op) ? fv + 8'h01
                                                                   : fv - 8'h01; // RQ13
                                route = 1'b1;
                                nxt_s.flags[STAT_Z] = (res == 8'h00);
                            end
                            decrement_skip_zero, increment_skip_zero:
                            begin
                                res   = (s_ff.op == increment_skip_zero) ? fv + 8'h01
                                                                          : fv - 8'h01;
                                route = 1'b1;
                                nxt_s.skip = (res == 8'h00); // RQ14 RQ15
                            end
                            bit_clear_op:  nxt_s.mem[s_ff.f][s_ff.b] = 1'b0; // RQ3
                            bit_set_op:    nxt_s.mem[s_ff.f][s_ff.b] = 1'b1; // RQ4
                            test_skip_if_clear: nxt_s.skip = !fv[s_ff.b]; // RQ7
                            test_skip_if_set:   nxt_s.skip = fv[s_ff.b]; // RQ6
                            and_literal_op:
                            begin
                                nxt_s.acc = s_ff.acc & s_ff.k[7:0]; // RQ5
                                nxt_s.flags[STAT_Z] = ((s_ff.acc & s_ff.k[7:0]) == 8'h00);
                            end
                            clear_register_op:
                            begin
                                nxt_s.mem[s_ff.f]   = 8'h00; // RQ8
                                nxt_s.flags[STAT_Z] = 1'b1;
                            end
                            clear_accumulator_op:
                            begin
                                nxt_s.acc           = 8'h00; // RQ9
                                nxt_s.flags[STAT_Z] = 1'b1;
                            end
                            call_op:
                            begin
                                // The stack wraps after eight pushes.
                                nxt_s.stack[s_ff.sp] = s_ff.pc + 13'h0001; // RQ10
                                nxt_s.sp  = s_ff.sp + 3'h1;
                                nxt_s.pc  = {s_ff.page[4:3], s_ff.k};
                                nxt_s.seq = SEQ_NOP; // RQ17
                            end
                            jump_op:
                            begin
                                nxt_s.pc  = {s_ff.page[4:3], s_ff.k}; // RQ11
                                nxt_s.seq = SEQ_NOP;
                            end
                            watchdog_clear_op:
                            begin
                                nxt_s.wdog_clr          = 1'b1; // RQ12
                                nxt_s.flags[STAT_TMOUT] = 1'b1;
                                nxt_s.flags[STAT_PWRDN] = 1'b1;
                            end
                            default: ;
                        endcase
                        if (route && s_ff.d)
                        begin
                            nxt_s.mem[s_ff.f] = res; // RQ1 RQ2 RQ13
                        end
                        else if (route)
                        begin
                            nxt_s.acc = res;
                        end
                    end
                end
            endcase
        end
    end

    // ****************************************************************
    // Registers
    // ****************************************************************
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            s_ff       <= '0;
            s_ff.acc   <= ACC_RST;
            s_ff.flags <= FLAGS_RST;
            s_ff.pc    <= PC_RST;
            s_ff.page  <= PAGE_RST;
        end
        else
        begin
            s_ff <= nxt_s;
        end
    end

    assign prdata         = s_ff.prdata;
    assign pready         = s_ff.pready;
    assign pslverr        = s_ff.pslverr;
    assign watchdog_clear = s_ff.wdog_clr;

    // ****************************************************************
    // Assertions
    // ****************************************************************
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_branch_fire;
        fire && (s_ff.op == call_op || s_ff.op == jump_op);
    endsequence
    sequence s_nop_cycle;
        (s_ff.seq == SEQ_NOP) [*4] ##1 (s_ff.seq == SEQ_IDLE);
    endsequence
    sequence s_discard;
        (s_ff.skip && !s_ff.tick) [*3] ##1 s_ff.tick;
    endsequence

    property p_tick;
        s_ff.tick |=> !s_ff.tick [*3] ##1 s_ff.tick;
    endproperty
    a_tick: assert property (p_tick) else $error("cycle tick spacing"); // RQ17

    property p_branch_nop;
        s_branch_fire |=> s_nop_cycle;
    endproperty
    a_branch_nop: assert property (p_branch_nop) else $error("no NOP cycle"); // RQ17

    property p_and_acc;
        fire && s_ff.op == and_acc_with_file && !s_ff.d
        |=> s_ff.acc == ($past(s_ff.acc) & $past(fv));
    endproperty
    a_and_acc: assert property (p_and_acc) else $error("AND result wrong"); // RQ1

    property p_add_carry;
        fire && s_ff.op == add_acc_to_file |=> s_ff.flags[STAT_C] == $past(add_sum[8]);
    endproperty
    a_add_carry: assert property (p_add_carry) else $error("add carry wrong"); // RQ2

    property p_bit_clear;
        fire && s_ff.op == bit_clear_op
        |=> !s_ff.mem[$past(s_ff.f)][$past(s_ff.b)] && $stable(s_ff.flags);
    endproperty
    a_bit_clear: assert property (p_bit_clear) else $error("bit clear wrong"); // RQ3

    property p_skip_set;
        fire && s_ff.op == test_skip_if_set && fv[s_ff.b] |=> s_discard;
    endproperty
    a_skip_set: assert property (p_skip_set) else $error("skip on set bit"); // RQ6

    property p_skip_clear;
        fire && s_ff.op == test_skip_if_clear && !fv[s_ff.b] |=> s_discard;
    endproperty
    a_skip_clear: assert property (p_skip_clear) else $error("skip on clear bit"); // RQ7

    property p_clr_reg;
        fire && s_ff.op == clear_register_op
        |=> s_ff.mem[$past(s_ff.f)] == 8'h00 && s_ff.flags[STAT_Z];
    endproperty
    a_clr_reg: assert property (p_clr_reg) else $error("clear register wrong"); // RQ8

    property p_clr_acc;
        fire && s_ff.op == clear_accumulator_op |=> s_ff.acc == 8'h00 && s_ff.flags[STAT_Z];
    endproperty
    a_clr_acc: assert property (p_clr_acc) else $error("clear acc wrong"); // RQ9

    property p_call;
        fire && s_ff.op == call_op
        |=> s_ff.pc == {$past(s_ff.page[4:3]), $past(s_ff.k)}
            && s_ff.stack[$past(s_ff.sp)] == $past(s_ff.pc) + 13'h0001;
    endproperty
    a_call: assert property (p_call) else $error("call push wrong"); // RQ10

    property p_jump;
        fire && s_ff.op == jump_op
        |=> s_ff.sp == $past(s_ff.sp) && s_ff.pc[10:0] == $past(s_ff.k);
    endproperty
    a_jump: assert property (p_jump) else $error("jump wrong"); // RQ11

    property p_wdog;
        fire && s_ff.op == watchdog_clear_op
        |=> s_ff.wdog_clr && s_ff.flags[STAT_TMOUT] && s_ff.flags[STAT_PWRDN] ##1 !s_ff.wdog_clr;
    endproperty
    a_wdog: assert property (p_wdog) else $error("watchdog clear wrong"); // RQ12

    property p_dsz;
        fire && s_ff.op == decrement_skip_zero && fv == 8'h01
        |=> s_ff.skip && $stable(s_ff.flags);
    endproperty
    a_dsz: assert property (p_dsz) else $error("decrement skip wrong"); // RQ14

endmodule // mxs_exec
`default_nettype wire

// >>> dv/mxs_exec_tb.sv
// Purpose: Self-checking bench for the instruction execution core.
// Assumes: Zero-wait APB slave, one command at a time.
// Notes:   Random operands from a fixed seed, with skip and carry corners forced.
`timescale 1ns/1ps
`default_nettype none
module mcu_instruction_exec_subset_tb;
    import mxs_pkg::*;

    // ****************************************************************
    // Signals
    // ****************************************************************
    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        watchdog_clear;
    int          n_fail;
    int          cmp_count;
    int          seed;
    int          wd_pulses;
    logic [31:0] rd;
    logic        er;

    mxs_exec i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .watchdog_clear(watchdog_clear));

    initial
    begin
        pclk = 1'b0;
        forever #(CLK_PERIOD_NS / 2.0) pclk = ~pclk;
    end

    always @(posedge pclk)
        if (watchdog_clear === 1'b1)
            wd_pulses <= wd_pulses + 1;

    // ****************************************************************
    // Tasks
    // ****************************************************************
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic final_report();
        $display("Comparisons %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int i;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        i = 0;
        do
        begin
            @(posedge pclk);
            i++;
        end
        while (pready !== 1'b1 && i < 16);
        if (pready !== 1'b1)
        begin
            n_fail++;
            final_report();
        end
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    // A command waits for the next cycle tick, so a short pause precedes the poll.
    task automatic issue(input logic [31:0] cmd);
        int i;
        apb(1'b1, ADDR_CMD, cmd);
        chk("cmd_err", {31'h0, er}, 32'h0);
        repeat (6) @(posedge pclk);
        i = 0;
        do
        begin
            apb(1'b0, ADDR_STATUS, 32'h0);
            i++;
        end
        while (rd[STAT_BUSY] !== 1'b0 && i < 12);
        if (rd[STAT_BUSY] !== 1'b0)
        begin
            n_fail++;
            final_report();
        end
    endtask

    // Returns {skip, flags, acc, file} after one instruction.
    function automatic logic [21:0] model(input logic [4:0] op, input logic [7:0] w,
        input logic [7:0] fv, input logic [2:0] b, input logic [7:0] k, input logic d,
        input logic [4:0] fl);
        logic [8:0] s;
        logic [4:0] s4;
        logic [7:0] r;
        logic [7:0] acc;
        logic [7:0] fil;
        logic       sk;
        logic       byt;
        s   = {1'b0, w} + {1'b0, fv};
        s4  = {1'b0, w[3:0]} + {1'b0, fv[3:0]};
        r   = 8'h00;
        acc = w;
        fil = fv;
        sk  = 1'b0;
        byt = 1'b1;
        case (op)
            and_acc_with_file: r = w & fv;
            add_acc_to_file:
            begin
                r = s[7:0];
                fl[STAT_C]  = s[8];
                fl[STAT_DIGIT] = s4[4];
            end
            complement_op: r = ~fv;
            increment_op, increment_skip_zero: r = fv + 8'h01;
            decrement_op, decrement_skip_zero: r = fv - 8'h01;
            default: byt = 1'b0;
        endcase
        if (byt)
        begin
            if (d)
                fil = r;
            else
                acc = r;
            if (op == decrement_skip_zero || op == increment_skip_zero)
                sk = (r == 8'h00);
            else
                fl[STAT_Z] = (r == 8'h00);
        end
        case (op)
            bit_clear_op: fil[b] = 1'b0;
            bit_set_op: fil[b] = 1'b1;
            test_skip_if_clear: sk = ~fv[b];
            test_skip_if_set: sk = fv[b];
            and_literal_op:
            begin
                acc = w & k;
                fl[STAT_Z] = (acc == 8'h00);
            end
            clear_register_op:
            begin
                fil = 8'h00;
                fl[STAT_Z] = 1'b1;
            end
            clear_accumulator_op:
            begin
                acc = 8'h00;
                fl[STAT_Z] = 1'b1;
            end
            default: ;
        endcase
        return {sk, fl, acc, fil};
    endfunction

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial
    begin
        logic [4:0]  op;
        logic [7:0]  w;
        logic [7:0]  fv;
        logic [6:0]  f;
        logic [2:0]  b;
        logic [10:0] k;
        logic        d;
        logic [4:0]  fl;
        logic [4:0]  pg;
        logic [21:0] ex;
        logic [12:0] pc0;
        logic [11:0] fa;
        int          n;
        seed      = 98708;
        n_fail    = 0;
        cmp_count = 0;
        presetn   = 1'b0;
        psel      = 1'b0;
        penable   = 1'b0;
        pwrite    = 1'b0;
        paddr     = 12'h000;
        pwdata    = 32'h0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, ADDR_ACC, 32'h0);
        chk("acc_reset", rd, {24'h0, ACC_RST});
        apb(1'b0, ADDR_STATUS, 32'h0);
        chk("status_reset", rd, {27'h0, FLAGS_RST});
        apb(1'b0, ADDR_PC, 32'h0);
        chk("pc_reset", rd, {19'h0, PC_RST});
        apb(1'b0, 12'h01C, 32'h0);
        chk("unmapped_err", {31'h0, er}, 32'h1);
        chk("unmapped_data", rd, 32'h0);
        for (int it = 0; it < 56; it++)
        begin
            op = 5'(it % 14);
            {w, fv, f, b, k, d, fl} = 43'($random(seed) ^ ($random(seed) << 11));
            if (it >= 42)
                case (op)
                    and_acc_with_file: fv = ~w;
                    add_acc_to_file: {w, fv} = 16'h8F71;
                    decrement_skip_zero: fv = 8'h01;
                    increment_skip_zero: fv = 8'hFF;
                    test_skip_if_clear: fv[b] = 1'b0;
                    test_skip_if_set: fv[b] = 1'b1;
                    default: ;
                endcase
            ex = model(op, w, fv, b, k[7:0], d, fl);
            fa = 12'h400 + {3'h0, f, 2'b00};
            apb(1'b1, ADDR_ACC, {24'h0, w});
            apb(1'b1, fa, {24'h0, fv});
            apb(1'b1, ADDR_STATUS, {27'h0, fl});
            apb(1'b0, ADDR_PC, 32'h0);
            pc0 = rd[12:0];
            issue({5'h0, k, b, d, f, op});
            apb(1'b0, ADDR_ACC, 32'h0);
            chk("acc", rd, {24'h0, ex[15:8]});
            apb(1'b0, fa, 32'h0);
            chk("file", rd, {24'h0, ex[7:0]});
            apb(1'b0, ADDR_STATUS, 32'h0);
            chk("flags", {27'h0, rd[4:0]}, {27'h0, ex[20:16]});
            chk("skip", {31'h0, rd[STAT_SKIP]}, {31'h0, ex[21]});
            apb(1'b0, ADDR_PC, 32'h0);
            chk("pc_step", rd, {19'h0, pc0 + 13'h1});
            if (ex[21])
            begin
                issue({19'h0, 1'b1, f, 5'(increment_op)});
                apb(1'b0, fa, 32'h0);
                chk("skipped_file", rd, {24'h0, ex[7:0]});
                apb(1'b0, ADDR_PC, 32'h0);
                chk("skipped_pc", rd, {19'h0, pc0 + 13'h2});
            end
        end
        for (int it = 0; it < 6; it++)
        begin
            op = it[0] ? jump_op : call_op;
            {pg, k} = 16'($random(seed));
            apb(1'b1, ADDR_PAGE, {27'h0, pg});
            apb(1'b0, ADDR_SP, 32'h0);
            n = int'(rd[2:0]);
            apb(1'b0, ADDR_PC, 32'h0);
            pc0 = rd[12:0];
            issue({5'h0, k, 11'h0, op});
            apb(1'b0, ADDR_PC, 32'h0);
            chk("branch_pc", rd, {19'h0, pg[4:3], k});
            if (op == call_op)
            begin
                apb(1'b0, ADDR_STACK_TOP, 32'h0);
                chk("call_push", rd, {19'h0, pc0 + 13'h1});
            end
            apb(1'b0, ADDR_SP, 32'h0);
            chk("branch_sp", {29'h0, rd[2:0]}, {29'h0, 3'(n + (op == call_op))});
        end
        apb(1'b1, ADDR_STATUS, 32'h0);
        n = wd_pulses;
        issue({27'h0, 5'(watchdog_clear_op)});
        apb(1'b0, ADDR_STATUS, 32'h0);
        chk("wdog_flags", {27'h0, rd[4:0]}, 32'h18);
        chk("wdog_pulse", 32'(wd_pulses - n), 32'h1);
        final_report();
    end
endmodule // mcu_instruction_exec_subset_tb
`default_nettype wire
